// [rtl/gpc_pkg.sv]
package gpc_pkg;

   // port and pin geometry: four ports of eight pin slots
   localparam int NPORT = 4;
   localparam int PW    = 8;
   localparam int NPIN  = NPORT * PW;
   localparam int AW    = 7;

   // flat pin indices of the pins with special duties
   localparam int PIN_PA0 = 0;
   localparam int PIN_PA1 = 1;
   localparam int PIN_PA2 = 2;
   localparam int PIN_PA6 = 6;
   localparam int PIN_PD0 = 24;

   // port numbers
   localparam logic [1:0] PORT_A = 2'h0;
   localparam logic [1:0] PORT_B = 2'h1;
   localparam logic [1:0] PORT_C = 2'h2;
   localparam logic [1:0] PORT_D = 2'h3;

   // per-port register offsets, address = {0, port[1:0], reg[3:0]}
   localparam logic [3:0] REG_OUT   = 4'h0;
   localparam logic [3:0] REG_DIR   = 4'h1;
   localparam logic [3:0] REG_ALT   = 4'h2;
   localparam logic [3:0] REG_AFLO  = 4'h3;
   localparam logic [3:0] REG_AFHI  = 4'h4;
   localparam logic [3:0] REG_OD    = 4'h5;
   localparam logic [3:0] REG_HD    = 4'h6;
   localparam logic [3:0] REG_PU    = 4'h7;
   localparam logic [3:0] REG_SMR   = 4'h8;
   localparam logic [3:0] REG_IN    = 4'h9;

   // global registers
   localparam logic [6:0] ADDR_LED_EN  = 7'h40;
   localparam logic [6:0] ADDR_LED_LVH = 7'h41;
   localparam logic [6:0] ADDR_LED_LVL = 7'h42;
   localparam logic [6:0] ADDR_SYS     = 7'h43;
   localparam logic [6:0] ADDR_STAT    = 7'h44;

   // field positions of the system and status registers
   localparam int SYS_PD0_GPIO  = 0;
   localparam int SYS_PA2_GPIO  = 1;
   localparam int STAT_DBG_UNLK = 0;
   localparam int STAT_XTAL     = 1;

   // reset values; direction bit high means input
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hff;
   localparam logic [1:0] SYS_RST = 2'h0;

   // package variants
   typedef enum logic [1:0] {
      GPC_PKG8  = 2'b00,
      GPC_PKG20 = 2'b01,
      GPC_PKG28 = 2'b10
   } gpc_variant_t;

   // software settings of one pin
   typedef struct packed {
      logic dout;
      logic dir_in;
      logic alt;
      logic af_lo;
      logic af_hi;
      logic od;
      logic hd;
      logic pu;
      logic smr;
   } gpc_cfg_t;

   // hard overrides of one pin
   typedef struct packed {
      logic xtal;
      logic fixed;
      logic f_out;
      logic f_oe;
   } gpc_ovr_t;

   // resolved pad controls of one pin
   typedef struct packed {
      logic val;
      logic oe_n;
      logic pu;
      logic hd;
   } gpc_drv_t;

endpackage

// [rtl/gpc_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser; deliberately without reset so that a reset pin
// held low is still seen while the rest of the block sits in reset
module gpc_sync #(
   parameter int W = 1
) (
   // clock
   input  wire logic         clock,
   // asynchronous level in, synchronised level out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clock)
   begin
      meta_q   <= async_in;
      sync_out <= meta_q;
   end

endmodule

// [rtl/gpc_pin_cell.sv]
`timescale 1ns/1ps
// pad resolution of one pin; purely combinational, top registers result
module gpc_pin_cell
   import gpc_pkg::*;
(
   // configuration and presence
   input  wire gpc_cfg_t cfg,
   input  wire logic     present,
   // peripheral function
   input  wire logic     alt_out,
   input  wire logic     alt_drive,
   // hard overrides
   input  wire gpc_ovr_t ovr,
   // pad controls
   output gpc_drv_t      drv
);

   logic drive_en;

   // crystal first, then debug or reset, then peripheral, then gpio
   always_comb
   begin
      drive_en = ~cfg.dir_in;
      drv      = '{val: 1'b0, oe_n: 1'b1, pu: 1'b0, hd: 1'b0};
      if (!present || ovr.xtal)                 // [RULE6] [RULE19]
      begin
         drv.oe_n = 1'b1;
      end
      else if (ovr.fixed)                       // [RULE19]
      begin
         drv.val  = ovr.f_out;
         drv.oe_n = ~ovr.f_oe;
      end
      else if (cfg.alt)                         // [RULE3] [RULE19]
      begin
         drv.val  = alt_out;
         drv.oe_n = ~alt_drive;
         drv.pu   = cfg.pu;
         drv.hd   = cfg.hd;
      end
      else if (cfg.od)
      begin
         // open drain pulls low only, a one releases the pad
         drv.oe_n = ~(drive_en & ~cfg.dout);
         drv.pu   = cfg.pu;
         drv.hd   = cfg.hd;
      end
      else
      begin
         drv.val  = cfg.dout;
         drv.oe_n = ~drive_en;
         drv.pu   = cfg.pu;
         drv.hd   = cfg.hd;
      end
   end

endmodule

// [rtl/gpc_port_ctrl.sv]
// Summary of operation
// RULE1: up to 25 pins, four ports, independent
// RULE2: per-pin direction, drain, drive, pull, recovery, function
// RULE3: alternate function owns pin direction
// RULE4: two set registers choose among functions
// RULE5: software sets set registers before enabling
// RULE6: crystal enable takes over port A pins 0,1
// RULE7: timer mode picks input or complement output
// RULE8: port C LED sink, four current levels
// RULE9: LED enable on; level high/low pick current
// RULE10: port D pin 0 starts as reset pin
// RULE11: port D pin 0 gpio is open-drain output only
// RULE12: port D pin 0 no pull, drive, recovery
// RULE13: 8-pin port A pin 2 gpio is bidirectional
// RULE14: system reset restores pin 2 reset function
// RULE15: 8-pin port A pin 0 powers up input
// RULE16: unlock frees pin for debug until reset
// RULE17: port A function enable selects function directly
// RULE18: pad inputs synchronised, settings clocked
// RULE19: crystal, debug/reset, peripheral, gpio priority
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module gpc_port_ctrl
   import gpc_pkg::*;
#(
   parameter gpc_variant_t VARIANT = GPC_PKG28
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              sys_rst,
   // register port
   input  wire logic [AW-1:0]     reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   // pads
   input  wire logic [NPIN-1:0]   pad_in,
   output logic      [NPIN-1:0]   pad_out,
   output logic      [NPIN-1:0]   pad_oe_n,
   output logic      [NPIN-1:0]   pad_pu,
   output logic      [NPIN-1:0]   pad_hd,
   // port C LED sink drivers
   output logic      [PW-1:0]     led_sink_en,
   output logic      [2*PW-1:0]   led_level,
   // peripheral functions
   input  wire logic [NPIN-1:0]   alt_out,
   input  wire logic [NPIN-1:0]   alt_drive,
   input  wire logic [1:0]        tmr_out_mode,
   output logic      [NPIN-1:0]   pin_sync,
   output logic      [2*NPIN-1:0] alt_sel,
   // oscillator, debug and reset
   input  wire logic              xtal_en,
   input  wire logic              dbg_window,
   input  wire logic              dbg_unlock,
   input  wire logic              dbg_out,
   input  wire logic              dbg_oe,
   input  wire logic              rst_drive,
   output logic                   dbg_unlocked,
   output logic                   ext_rst_req,
   output logic                   smr_wake
);

   logic [NPORT-1:0][PW-1:0] out_q, dir_q, alt_q, aflo_q, afhi_q;
   logic [NPORT-1:0][PW-1:0] od_q, hd_q, pu_q, smr_q;
   logic [PW-1:0]            led_en_q, led_lvh_q, led_lvl_q;
   logic [1:0]               sys_q;
   logic [NPIN-1:0]          in_sync, in_prev_q, in_view;
   gpc_cfg_t                 cfg [NPIN];
   gpc_ovr_t                 ovr [NPIN];
   gpc_drv_t                 drv [NPIN];
   logic [NPIN-1:0]          drive_sel;
   logic [7:0]               rd_val;
   logic                     pd0_rst_mode, pa2_rst_mode, pa0_dbg;
   logic                     is8;

   // which pin slots exist on this package
   function automatic logic pin_present(input int idx);
      logic [1:0] p;
      int         b;
      p = 2'(idx / PW);
      b = idx % PW;
      case (VARIANT)
         GPC_PKG8:  pin_present = (p == PORT_A) && (b < 6);
         GPC_PKG20: pin_present = (p == PORT_A) || (p == PORT_D && b == 0)
                                  || ((p == PORT_B || p == PORT_C) && b < 4);
         default:   pin_present = (p != PORT_D) || (b == 0);
      endcase
   endfunction

   // port field of a per-port address, shared by write and read decode
   function automatic logic [1:0] addr_port(input logic [AW-1:0] a);
      addr_port = a[5:4];
   endfunction

   // true when a set register exists for the port
   function automatic logic has_sets(input logic [1:0] p);
      has_sets = (p == PORT_B) || (p == PORT_C);
   endfunction

   // port C pins that exist on this package, the only LED sinks
   function automatic logic [PW-1:0] led_mask();
      for (int b = 0; b < PW; b++)
         led_mask[b] = pin_present(2*PW + b);
   endfunction

   // recovery enables of present pins, port D pin 0 never counts
   function automatic logic [NPIN-1:0] smr_bits();
      for (int i = 0; i < NPIN; i++)
         smr_bits[i] = cfg[i].smr & pin_present(i);
   endfunction

   assign is8          = (VARIANT == GPC_PKG8);
   assign pd0_rst_mode = !is8 && !sys_q[SYS_PD0_GPIO];          // [RULE10]
   assign pa2_rst_mode = is8 && !sys_q[SYS_PA2_GPIO];           // [RULE14]
   assign pa0_dbg      = is8 && dbg_unlocked;                   // [RULE16]

   // pad inputs cross into the clock domain before any use
   gpc_sync #(.W(NPIN)) u_sync (
      .clock    (clock),
      .async_in (pad_in),
      .sync_out (in_sync)                                      // [RULE18]
   );

   // per-port settings; settings change only on clock edges
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         out_q  <= {NPORT{CFG_RST}};
         dir_q  <= {NPORT{DIR_RST}};                            // [RULE15]
         alt_q  <= {NPORT{CFG_RST}};
         aflo_q <= {NPORT{CFG_RST}};
         afhi_q <= {NPORT{CFG_RST}};
         od_q   <= {NPORT{CFG_RST}};
         hd_q   <= {NPORT{CFG_RST}};
         pu_q   <= {NPORT{CFG_RST}};
         smr_q  <= {NPORT{CFG_RST}};
      end
      else if (reg_wr && !reg_addr[6])                          // [RULE18]
      begin
         case (reg_addr[3:0])                                   // [RULE2]
            REG_OUT:  out_q[addr_port(reg_addr)]  <= reg_wdata;
            REG_DIR:  dir_q[addr_port(reg_addr)]  <= reg_wdata;
            REG_ALT:  alt_q[addr_port(reg_addr)]  <= reg_wdata;
            REG_AFLO:
               if (has_sets(addr_port(reg_addr)))               // [RULE17]
                  aflo_q[addr_port(reg_addr)] <= reg_wdata;
            REG_AFHI:
               if (has_sets(addr_port(reg_addr)))
                  afhi_q[addr_port(reg_addr)] <= reg_wdata;
            REG_OD:   od_q[addr_port(reg_addr)]   <= reg_wdata;
            REG_HD:   hd_q[addr_port(reg_addr)]   <= reg_wdata;
            REG_PU:   pu_q[addr_port(reg_addr)]   <= reg_wdata;
            REG_SMR:  smr_q[addr_port(reg_addr)]  <= reg_wdata;
            default:  ;
         endcase
      end
   end

   // global LED and pin-mode settings; any reset restores reset pins
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         led_en_q  <= CFG_RST;
         led_lvh_q <= CFG_RST;
         led_lvl_q <= CFG_RST;
         sys_q     <= SYS_RST;                   // [RULE10] [RULE14]
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            ADDR_LED_EN:  led_en_q  <= reg_wdata;               // [RULE9]
            ADDR_LED_LVH: led_lvh_q <= reg_wdata;               // [RULE9]
            ADDR_LED_LVL: led_lvl_q <= reg_wdata;
            ADDR_SYS:     sys_q     <= reg_wdata[1:0];
            default:      ;
         endcase
      end
   end

   // debug unlock is seen only inside the reset sequence window and
   // then holds until the next reset; later unlock pulses are ignored
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         dbg_unlocked <= 1'b0;
      else if (is8 && dbg_window && dbg_unlock)                 // [RULE16]
         dbg_unlocked <= 1'b1;
   end

   // software settings per pin, with port D pin 0 restrictions
   always_comb
   begin
      for (int i = 0; i < NPIN; i++)
      begin
         cfg[i] = '{dout:   out_q[i/PW][i%PW],
                    dir_in: dir_q[i/PW][i%PW],
                    alt:    alt_q[i/PW][i%PW],                  // [RULE17]
                    af_lo:  aflo_q[i/PW][i%PW],
                    af_hi:  afhi_q[i/PW][i%PW],
                    od:     od_q[i/PW][i%PW],
                    hd:     hd_q[i/PW][i%PW],
                    pu:     pu_q[i/PW][i%PW],
                    smr:    smr_q[i/PW][i%PW]};
      end
      cfg[PIN_PD0].dir_in = 1'b0;                               // [RULE11]
      cfg[PIN_PD0].od     = 1'b1;                               // [RULE11]
      cfg[PIN_PD0].pu     = 1'b0;                               // [RULE12]
      cfg[PIN_PD0].hd     = 1'b0;                               // [RULE12]
      cfg[PIN_PD0].smr    = 1'b0;                               // [RULE12]
   end

   // hard overrides: crystal, unlocked debug, reset function
   always_comb
   begin
      for (int i = 0; i < NPIN; i++)
         ovr[i] = '{xtal: 1'b0, fixed: 1'b0, f_out: 1'b0, f_oe: 1'b0};
      ovr[PIN_PA0].xtal = xtal_en;                              // [RULE6]
      ovr[PIN_PA1].xtal = xtal_en;                              // [RULE6]
      if (pa0_dbg)
         ovr[PIN_PA0] = '{xtal: xtal_en, fixed: 1'b1,
                          f_out: dbg_out, f_oe: dbg_oe};        // [RULE16]
      // reset pins pull low only while the chip drives reset out
      if (pd0_rst_mode)
         ovr[PIN_PD0] = '{xtal: 1'b0, fixed: 1'b1,
                          f_out: 1'b0, f_oe: rst_drive};        // [RULE10]
      if (pa2_rst_mode)
         ovr[PIN_PA2] = '{xtal: 1'b0, fixed: 1'b1,
                          f_out: 1'b0, f_oe: rst_drive};        // [RULE14]
   end

   // peripheral direction; timer pins follow the timer mode
   always_comb
   begin
      drive_sel          = alt_drive;
      drive_sel[PIN_PA0] = tmr_out_mode[0];                     // [RULE7]
      drive_sel[PIN_PA6] = tmr_out_mode[1];                     // [RULE7]
   end

   // one resolver per pin slot
   for (genvar g = 0; g < NPIN; g++)
   begin : g_pin
      gpc_pin_cell u_cell (
         .cfg       (cfg[g]),
         .present   (pin_present(g)),                           // [RULE1]
         .alt_out   (alt_out[g]),
         .alt_drive (drive_sel[g]),
         .ovr       (ovr[g]),
         .drv       (drv[g])
      );
   end

   // data view of the pins; port D pin 0 and the unlocked debug pin read zero
   always_comb
   begin
      for (int i = 0; i < NPIN; i++)
         in_view[i] = in_sync[i] & pin_present(i);              // [RULE13]
      if (!is8)
         in_view[PIN_PD0] = 1'b0;                               // [RULE11]
      if (pa0_dbg)
         in_view[PIN_PA0] = 1'b0;                               // [RULE16]
   end

   // pad outputs registered so every pad control is glitch free
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pad_out  <= '0;
         pad_oe_n <= '1;
         pad_pu   <= '0;
         pad_hd   <= '0;
      end
      else
      begin
         for (int i = 0; i < NPIN; i++)
         begin
            pad_out[i]  <= drv[i].val;
            pad_oe_n[i] <= drv[i].oe_n;                         // [RULE19]
            pad_pu[i]   <= drv[i].pu;
            pad_hd[i]   <= drv[i].hd;
         end
      end
   end

   // peripheral side: synced pins and function selects
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_sync <= '0;
         alt_sel  <= '0;
      end
      else
      begin
         pin_sync <= in_view;
         for (int i = 0; i < NPIN; i++)
            alt_sel[2*i +: 2] <= has_sets(2'(i / PW)) ? // [RULE4]
                                 {cfg[i].af_hi, cfg[i].af_lo} : 2'b00;
      end
   end

   // LED sink drivers; only present port C pins can sink
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         led_sink_en <= '0;
         led_level   <= '0;
      end
      else
      begin
         led_sink_en <= led_en_q & led_mask();                    // [RULE9]
         for (int b = 0; b < PW; b++)
            led_level[2*b +: 2] <= {led_lvh_q[b], led_lvl_q[b]};  // [RULE8]
      end
   end

   // recovery wake on any change of an enabled pin
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         in_prev_q <= '0;
         smr_wake  <= 1'b0;
      end
      else
      begin
         in_prev_q <= in_sync;
         smr_wake  <= |((in_sync ^ in_prev_q) & smr_bits()); // [RULE18]
      end
   end

   // external reset request; not reset so a held-low pin keeps it up
   always_ff @(posedge clock)
   begin
      ext_rst_req <= (pd0_rst_mode && !in_sync[PIN_PD0])
                     || (pa2_rst_mode && !in_sync[PIN_PA2]);    // [RULE14]
   end

   // read data for the addressed register
   always_comb
   begin
      rd_val = 8'h00;
      if (!reg_addr[6])
      begin
         case (reg_addr[3:0])
            REG_OUT:  rd_val = out_q[addr_port(reg_addr)];
            REG_DIR:  rd_val = dir_q[addr_port(reg_addr)];
            REG_ALT:  rd_val = alt_q[addr_port(reg_addr)];
            REG_AFLO: rd_val = aflo_q[addr_port(reg_addr)];
            REG_AFHI: rd_val = afhi_q[addr_port(reg_addr)];
            REG_OD:   rd_val = od_q[addr_port(reg_addr)];
            REG_HD:   rd_val = hd_q[addr_port(reg_addr)];
            REG_PU:   rd_val = pu_q[addr_port(reg_addr)];
            REG_SMR:  rd_val = smr_q[addr_port(reg_addr)];
            REG_IN:   rd_val = in_view[8*addr_port(reg_addr) +: 8];
            default:  rd_val = 8'h00;
         endcase
      end
      else
      begin
         case (reg_addr)
            ADDR_LED_EN:  rd_val = led_en_q;
            ADDR_LED_LVH: rd_val = led_lvh_q;
            ADDR_LED_LVL: rd_val = led_lvl_q;
            ADDR_SYS:     rd_val = {6'h00, sys_q};
            ADDR_STAT:    rd_val = {6'h00, xtal_en, dbg_unlocked};
            default:      rd_val = 8'h00;
         endcase
      end
   end

   // read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? rd_val : 8'h00;
   end

   // checks
   AST_XTAL_OVR: assert property (@(posedge clock) disable iff (sys_rst)
      xtal_en |=> pad_oe_n[PIN_PA0] && pad_oe_n[PIN_PA1]) // [RULE6]
      else $error("crystal pins still driven");

   AST_ALT_DIR: assert property (@(posedge clock) disable iff (sys_rst)
      alt_q[0][3] |=> pad_oe_n[3] == !$past(alt_drive[3])) // [RULE3]
      else $error("alternate function did not own direction");

   AST_PD0_NOPU: assert property (@(posedge clock) disable iff (sys_rst)
      !pad_pu[PIN_PD0] && !pad_hd[PIN_PD0]) // [RULE12]
      else $error("port D pin 0 pull or drive set");

   AST_PD0_OD: assert property (@(posedge clock) disable iff (sys_rst)
      (!is8 && !pd0_rst_mode) |=> !pad_out[PIN_PD0]) // [RULE11]
      else $error("port D pin 0 drove high");

   AST_RD_BACK: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_wr && reg_addr == {1'b0, PORT_B, REG_DIR}) ##1 !reg_wr ##1
      (reg_rd && reg_addr == $past(reg_addr, 2))
      |=> reg_rdata == $past(reg_wdata, 3)) // [RULE2]
      else $error("direction read back differs");

   AST_RD_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");

   AST_DBG_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
      dbg_unlocked |=> dbg_unlocked [*3]) // [RULE16]
      else $error("debug unlock lost before reset");

   AST_EXT_RST: assert property (@(posedge clock) disable iff (sys_rst)
      (pa2_rst_mode && !in_sync[PIN_PA2]) |=> ext_rst_req) // [RULE14]
      else $error("held reset pin not requesting reset");

   AST_LED_EN: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_wr && reg_addr == ADDR_LED_EN) ##1 !(reg_wr
      && reg_addr == ADDR_LED_EN) |=> led_sink_en
      == ($past(reg_wdata, 2) & led_mask())) // [RULE9]
      else $error("LED enable not applied");

   COV_XTAL: cover property (@(posedge clock) disable iff (sys_rst)
      xtal_en ##1 pad_oe_n[PIN_PA0]);
   COV_DBG: cover property (@(posedge clock) disable iff (sys_rst)
      $rose(dbg_unlocked));
   COV_LED: cover property (@(posedge clock) disable iff (sys_rst)
      |led_sink_en);
   COV_RST: cover property (@(posedge clock) disable iff (sys_rst)
      ext_rst_req);

endmodule

// [bench/gpc_pad_model.sv]
`timescale 1ns/1ps
// pins as the outside sees them; a floating pin toggles each cycle
// so that a stale level can never pass for a driven one
module gpc_pad_model
   import gpc_pkg::*;
(
   // clock
   clock,
   // chip pad controls
   pad_out,
   pad_oe_n,
   pad_pu,
   // outside drivers
   ext_en,
   ext_val,
   // resolved levels
   pad_in
);
   input  wire logic [NPIN-1:0] pad_out, pad_oe_n, pad_pu, ext_en, ext_val;
   input  wire logic            clock;
   output logic      [NPIN-1:0] pad_in;
   logic float_q = 1'b0;
   // floating pattern
   always_ff @(posedge clock)
   begin
      float_q <= ~float_q;
   end
   // chip drive wins, then outside drive, then pull-up
   always_comb
   begin
      for (int i = 0; i < NPIN; i++)
         pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i]
                   : pad_pu[i] ? 1'b1 : float_q;
   end
endmodule

// [bench/gpc_port_ctrl_tb.sv]
`timescale 1ns/1ps
module gpc_port_ctrl_tb
   import gpc_pkg::*;
();
   logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic xtal_en = 1'b0, rst_drive = 1'b0;
   logic dbg_unlocked, ext_rst_req, smr_wake;
   logic [AW-1:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0, reg_rdata, led_sink_en;
   logic [NPIN-1:0] pad_in, pad_out, pad_oe_n, pad_pu, pad_hd, pin_sync;
   logic [NPIN-1:0] alt_out = '0, alt_drive = '0, ext_en = '0, ext_val = '0;
   logic [15:0] led_level;
   logic [1:0] tmr_out_mode = 2'h0;
   logic [2*NPIN-1:0] alt_sel;
   int failures = 0, checks_done = 0;
   logic [NPIN-1:0] p8_in = '1, p8_out, p8_oe_n;
   logic p8_win = 1'b0, p8_unlk = 1'b0, p8_dbg, p8_rst;
   // debugger inputs tied: unlock only exists on the 8-pin variant
   gpc_port_ctrl i_gpc_port_ctrl (.clock(clock), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pu(pad_pu),
      .pad_hd(pad_hd), .led_sink_en(led_sink_en), .led_level(led_level),
      .alt_out(alt_out), .alt_drive(alt_drive), .tmr_out_mode(tmr_out_mode),
      .pin_sync(pin_sync), .alt_sel(alt_sel), .xtal_en(xtal_en),
      .dbg_window(1'b0), .dbg_unlock(1'b0), .dbg_out(1'b0), .dbg_oe(1'b0),
      .rst_drive(rst_drive), .dbg_unlocked(dbg_unlocked),
      .ext_rst_req(ext_rst_req), .smr_wake(smr_wake));
   // 8-pin part on the same bus; its pads are driven by the bench
   gpc_port_ctrl #(.VARIANT(GPC_PKG8)) i_gpc_port_ctrl_pkg8 (.clock(clock),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .pad_in(p8_in),
      .pad_out(p8_out), .pad_oe_n(p8_oe_n), .pad_pu(), .pad_hd(),
      .led_sink_en(), .led_level(), .alt_out(alt_out),
      .alt_drive(alt_drive), .tmr_out_mode(tmr_out_mode), .pin_sync(),
      .alt_sel(), .xtal_en(xtal_en), .dbg_window(p8_win),
      .dbg_unlock(p8_unlk), .dbg_out(1'b1), .dbg_oe(1'b1),
      .rst_drive(rst_drive), .dbg_unlocked(p8_dbg), .ext_rst_req(p8_rst),
      .smr_wake());
   gpc_pad_model i_gpc_pad_model (.clock(clock), .pad_out(pad_out),
      .pad_oe_n(pad_oe_n), .pad_pu(pad_pu), .ext_en(ext_en),
      .ext_val(ext_val), .pad_in(pad_in));
   // 50 mhz clock
   always #10 clock = ~clock;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk({24'h0, reg_rdata}, {24'h0, e});
   endtask
   // registers take one edge, pads one more
   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog, far above the hundred or so cycles the tests need
   initial
   begin
      #100000;
      failures++;
      print_verdict();
   end
   initial
   begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      rd(7'h11, DIR_RST);
      chk(pad_oe_n, 32'hffffffff);
      chk(p8_oe_n[5:0], 6'h3f);
      @(posedge clock);
      rst_drive <= 1'b1;
      ext_en[24] <= 1'b1;
      settle();
      chk({pad_oe_n[24], pad_out[24]}, 2'b00);
      repeat (2) @(posedge clock);
      #1 chk(ext_rst_req, 1'b1);
      rst_drive <= 1'b0;
      ext_val[24] <= 1'b1;
      wr(7'h11, 8'hf0);
      wr(7'h10, 8'h55);
      settle();
      chk({pad_oe_n[15:8], pad_out[11:8]}, 12'hf05);
      rd(7'h11, 8'hf0);
      @(posedge clock);
      ext_en[15:12] <= 4'hf;
      ext_val[15:12] <= 4'h9;
      repeat (4) @(posedge clock);
      ext_val[15:12] <= 4'h6;
      @(posedge clock);
      #1 chk(pin_sync[15:12], 4'h9);
      repeat (3) @(posedge clock);
      #1 chk(pin_sync[15:12], 4'h6);
      wr(7'h13, 8'h01);
      wr(7'h14, 8'h02);
      wr(7'h12, 8'h03);
      alt_drive[9] <= 1'b1;
      settle();
      chk(pad_oe_n[9:8], 2'b01);
      chk(alt_sel[19:16], 4'h9);
      wr(7'h03, 8'hff);
      rd(7'h03, 8'h00);
      wr(7'h01, 8'h00);
      wr(7'h02, 8'h09);
      tmr_out_mode <= 2'h1;
      settle();
      chk(pad_oe_n[0], 1'b0);
      tmr_out_mode <= 2'h0;
      settle();
      chk(pad_oe_n[0], 1'b1);
      @(posedge clock);
      xtal_en <= 1'b1;
      settle();
      chk(pad_oe_n[1:0], 2'b11);
      rd(7'h44, 8'h02);
      wr(7'h40, 8'hff);
      wr(7'h41, 8'haa);
      wr(7'h42, 8'h55);
      settle();
      chk(led_sink_en, 8'hff);
      chk(led_level, 16'h9999);
      wr(7'h43, 8'h01);
      wr(7'h37, 8'h01);
      wr(7'h36, 8'h01);
      wr(7'h30, 8'h00);
      settle();
      chk({pad_pu[24], pad_hd[24]}, 2'b00);
      chk(pad_oe_n[24], 1'b0);
      wr(7'h30, 8'h01);
      settle();
      chk(pad_oe_n[24], 1'b1);
      rd(7'h39, 8'h00);
      rd(7'h7f, 8'h00);
      wr(7'h11, 8'h3c);
      rd(7'h11, 8'h3c);
      wr(7'h18, 8'h10);
      ext_val[12] <= 1'b1;
      repeat (3) @(posedge clock);
      #1 chk(smr_wake, 1'b1);
      @(posedge clock);
      #1 chk(smr_wake, 1'b0);
      xtal_en <= 1'b0;
      p8_win <= 1'b1;
      p8_unlk <= 1'b1;
      @(posedge clock);
      p8_win <= 1'b0;
      p8_unlk <= 1'b0;
      settle();
      chk({p8_dbg, p8_oe_n[0], p8_out[0]}, 3'b101);
      p8_in[2] <= 1'b0;
      repeat (3) @(posedge clock);
      #1 chk(p8_rst, 1'b1);
      wr(7'h43, 8'h02);
      wr(7'h00, 8'h04);
      settle();
      chk({p8_rst, p8_oe_n[2], p8_out[2]}, 3'b001);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      settle();
      chk({p8_rst, p8_dbg, p8_oe_n[0]}, 3'b101);
      print_verdict();
   end
endmodule
